/* File: common/dec_pkg.sv */
/*
  Shared constants and types for the bit, branch and debug decoder.
  Assumes a 32-bit APB register port and a 16-bit synchronous external bus.
*/
package dec_pkg;
  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OPWORD = 8'h04;
  localparam logic [7:0] ADDR_EXT = 8'h08;
  localparam logic [7:0] ADDR_BITSRC = 8'h0C;
  localparam logic [7:0] ADDR_DST = 8'h10;
  localparam logic [7:0] ADDR_PC = 8'h14;
  localparam logic [7:0] ADDR_SR = 8'h18;
  localparam logic [7:0] ADDR_RESULT = 8'h1C;
  localparam logic [7:0] ADDR_SSP = 8'h20;
  localparam logic [7:0] ADDR_VBR = 8'h24;
  localparam logic [7:0] ADDR_STAT = 8'h28;
  // Control and status bit positions
  localparam int CTRL_BGEN = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_RESUME = 2;
  localparam int STAT_EXC = 8;
  localparam int FLAG_Z = 2;
  // Opcode patterns
  localparam logic [3:0] GRP_BIT = 4'h0;
  localparam logic [2:0] BTC_DYN = 3'h6;
  localparam logic [2:0] BTS_DYN = 3'h7;
  localparam logic [9:0] BTC_STAT = 10'h022;
  localparam logic [9:0] BTS_STAT = 10'h023;
  localparam logic [7:0] IMM_HI_ZERO = 8'h00;
  localparam logic [15:0] BACKGROUND_ENTRY_OP_WORD = 16'h4AFA;
  localparam logic [12:0] BREAKPOINT_OP_PFX = 13'h0909;
  localparam logic [7:0] BRA_PFX = 8'h60;
  localparam logic [7:0] DISP_WORD = 8'h00;
  localparam logic [7:0] DISP_LONG = 8'hFF;
  // Effective-address mode and register codes
  localparam logic [2:0] MODE_DREG = 3'h0;
  localparam logic [2:0] MODE_AREG = 3'h1;
  localparam logic [2:0] MODE_EXT = 3'h7;
  localparam logic [2:0] REG_ABSW = 3'h0;
  localparam logic [2:0] REG_ABSL = 3'h1;
  // Program counter steps and exception frame
  localparam logic [31:0] PC_STEP = 32'h0000_0002;
  localparam logic [31:0] IMM_LEN = 32'h0000_0004;
  localparam logic [31:0] BYTE_STEP = 32'h0000_0001;
  localparam logic [31:0] VEC_ILL_OFS = 32'h0000_0010;
  localparam logic [15:0] FVO_ILL = 16'h0010;
  // External bus cycle typing
  localparam logic [2:0] FC_CPU = 3'h7;
  localparam logic [2:0] FC_SUPV_DATA = 3'h5;
  localparam logic [3:0] CPU_TYPE_BREAKPOINT_OP = 4'h0;
  localparam logic [1:0] ACK_NONE = 2'h0;
  localparam logic [1:0] ACK_BYTE = 2'h1;
  localparam logic [1:0] STEP_ONE = 2'h1;
  localparam logic [1:0] STEP_LAST = 2'h3;

  typedef enum logic [2:0] {
    OP_ILL, OP_BTC, OP_BTS, OP_BACKGROUND_ENTRY_OP, OP_BREAKPOINT_OP, OP_BRA
  } op_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_EXEC = 6'h02,
    ST_ACK = 6'h04,
    ST_FROZEN = 6'h08,
    ST_PUSH = 6'h10,
    ST_VEC = 6'h20
  } state_t;
endpackage

/* File: rtl/op_classifier.sv */
/*
  Opcode classifier: sorts one opcode word into an operation kind.
  Assumes the first extension word's upper byte is presented alongside.
*/
`timescale 1ns/1ns
module op_classifier (
  input wire logic [15:0] opword,
  input wire logic [7:0] ext_hi,
  output dec_pkg::op_t kind,
  output logic imm_form,
  output logic dreg_dst
);
  // Data-alterable destinations only; address register and PC forms refused
  function automatic logic ea_data_alt(input logic [2:0] m, input logic [2:0] r);
    ea_data_alt = (m != dec_pkg::MODE_AREG) && ((m != dec_pkg::MODE_EXT)
      || (r == dec_pkg::REG_ABSW) || (r == dec_pkg::REG_ABSL));
  endfunction

  wire logic ea_ok;
  wire logic grp_ok;
  wire logic imm_ok;
  wire logic btc_hit;
  wire logic bts_hit;

  // Pattern matches for each decoded form
  assign ea_ok = ea_data_alt(opword[5:3], opword[2:0]);
  assign grp_ok = (opword[15:12] == dec_pkg::GRP_BIT);
  assign imm_ok = (ext_hi == dec_pkg::IMM_HI_ZERO);
  assign btc_hit = ea_ok && ((grp_ok && opword[8:6] == dec_pkg::BTC_DYN)
    || (opword[15:6] == dec_pkg::BTC_STAT && imm_ok));
  assign bts_hit = ea_ok && ((grp_ok && opword[8:6] == dec_pkg::BTS_DYN)
    || (opword[15:6] == dec_pkg::BTS_STAT && imm_ok));
  assign imm_form = (opword[15:6] == dec_pkg::BTC_STAT)
    || (opword[15:6] == dec_pkg::BTS_STAT);
  assign dreg_dst = (opword[5:3] == dec_pkg::MODE_DREG);

  // Anything unmatched falls through to the illegal path
  assign kind = btc_hit ? dec_pkg::OP_BTC :
    bts_hit ? dec_pkg::OP_BTS :
    (opword == dec_pkg::BACKGROUND_ENTRY_OP_WORD) ? dec_pkg::OP_BACKGROUND_ENTRY_OP :
    (opword[15:3] == dec_pkg::BREAKPOINT_OP_PFX) ? dec_pkg::OP_BREAKPOINT_OP :
    (opword[15:8] == dec_pkg::BRA_PFX) ? dec_pkg::OP_BRA :
    dec_pkg::OP_ILL;
endmodule

/* File: rtl/bit_op_unit.sv */
/*
  Bit test-and-modify datapath for the clear and set operations.
  Assumes the caller supplies the destination value and the bit number.
*/
`timescale 1ns/1ns
module bit_op_unit (
  input wire logic [31:0] operand,
  input wire logic [31:0] bit_src,
  input wire logic long_op,
  input wire logic set_bit,
  output logic [31:0] result,
  output logic was_zero
);
  wire logic [4:0] idx;
  wire logic [31:0] mask;
  wire logic [31:0] full;

  // Register targets wrap at 32, byte targets at 8; bit 0 is the LSB
  assign idx = long_op ? bit_src[4:0] : {2'b00, bit_src[2:0]};
  assign mask = 32'h0000_0001 << idx;
  // Flag taken from the bit before it is changed
  assign was_zero = ~|(operand & mask);
  assign full = set_bit ? (operand | mask) : (operand & ~mask);
  // Memory targets are byte wide, so upper bits read back as zero
  assign result = long_op ? full : {24'h00_0000, full[7:0]};
endmodule

/* File: rtl/bit_branch_debug_op_decoder.sv */
/*
  Decode-and-execute block for bit test-and-clear/set, background entry,
  breakpoint acknowledge and branch-always, with an APB register port.
  Assumes the external bus logic runs on sys_clk and answers each cycle.
*/
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ns
module bit_branch_debug_op_decoder (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic bus_req,
  output logic bus_wr,
  output logic [2:0] bus_fc,
  output logic [31:0] bus_addr,
  output logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic [1:0] data_size_ack,
  input wire logic bus_error_in,
  output logic freeze
);
  dec_pkg::state_t state_q;
  dec_pkg::op_t kind;
  logic [1:0] step_q;
  logic half_q;
  logic exc_q;
  logic bgen_q;
  logic [15:0] cap_q;
  logic [15:0] opword_q;
  logic [31:0] ext_q;
  logic [31:0] bitsrc_q;
  logic [31:0] dst_q;
  logic [31:0] pc_q;
  logic [15:0] sr_q;
  logic [31:0] result_q;
  logic [31:0] ssp_q;
  logic [31:0] vbr_q;
  logic bus_req_q;
  logic bus_wr_q;
  logic [2:0] bus_fc_q;
  logic [31:0] bus_addr_q;
  logic [15:0] bus_wdata_q;
  logic imm_form;
  logic dreg_dst;
  logic [31:0] bit_res;
  logic bit_zero;
  logic [31:0] rd_mux;
  logic hit;

  // Word pushed at each step of the exception frame
  function automatic logic [15:0] frame_word(input logic [1:0] s, input logic [31:0] pc,
                                             input logic [15:0] sr);
    case (s)
      2'h0: frame_word = dec_pkg::FVO_ILL;
      2'h1: frame_word = pc[15:0];
      2'h2: frame_word = pc[31:16];
      default: frame_word = sr;
    endcase
  endfunction

  op_classifier u_cls (
    .opword(opword_q),
    .ext_hi(ext_q[31:24]),
    .kind(kind),
    .imm_form(imm_form),
    .dreg_dst(dreg_dst)
  );

  wire logic [31:0] bit_src;
  // Bit number from the extension word or from the data register value
  assign bit_src = imm_form ? {24'h00_0000, ext_q[23:16]} : bitsrc_q;

  bit_op_unit u_bit (
    .operand(dst_q),
    .bit_src(bit_src),
    .long_op(dreg_dst),
    .set_bit(kind == dec_pkg::OP_BTS),
    .result(bit_res),
    .was_zero(bit_zero)
  );

  // APB decode; zero wait states, so every access ends in its first access cycle
  wire logic apb_wr;
  wire logic start;
  wire logic resume;
  assign apb_wr = psel && penable && pwrite;
  assign start = apb_wr && (paddr == dec_pkg::ADDR_CTRL) && pwdata[dec_pkg::CTRL_START];
  assign resume = apb_wr && (paddr == dec_pkg::ADDR_CTRL) && pwdata[dec_pkg::CTRL_RESUME];
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = (psel && !pwrite) ? rd_mux : 32'h0000_0000;

  // Read mux over the register map; unmapped addresses flag an error
  always_comb
  begin
    hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      dec_pkg::ADDR_CTRL: rd_mux[dec_pkg::CTRL_BGEN] = bgen_q;
      dec_pkg::ADDR_OPWORD: rd_mux[15:0] = opword_q;
      dec_pkg::ADDR_EXT: rd_mux = ext_q;
      dec_pkg::ADDR_BITSRC: rd_mux = bitsrc_q;
      dec_pkg::ADDR_DST: rd_mux = dst_q;
      dec_pkg::ADDR_PC: rd_mux = pc_q;
      dec_pkg::ADDR_SR: rd_mux[15:0] = sr_q;
      dec_pkg::ADDR_RESULT: rd_mux = result_q;
      dec_pkg::ADDR_SSP: rd_mux = ssp_q;
      dec_pkg::ADDR_VBR: rd_mux = vbr_q;
      dec_pkg::ADDR_STAT: rd_mux = {23'h00_0000, exc_q, 2'b00, state_q};
      default: hit = 1'b0;
    endcase
  end

  // Branch displacement: 0x00 takes the next word, 0xFF the next long word
  wire logic [31:0] disp;
  wire logic [31:0] breakpoint_op_addr;
  wire logic bus_done;
  wire logic exec_exc;
  assign disp = (opword_q[7:0] == dec_pkg::DISP_WORD) ? {{16{ext_q[31]}}, ext_q[31:16]} :
    (opword_q[7:0] == dec_pkg::DISP_LONG) ? ext_q :
    {{24{opword_q[7]}}, opword_q[7:0]};
  // CPU space type zero in bits 19-16, breakpoint number on bits 4-2
  assign breakpoint_op_addr = {12'h000, dec_pkg::CPU_TYPE_BREAKPOINT_OP, 11'h000, opword_q[2:0], 2'b00};
  // The far end always finishes a cycle with an acknowledge or an error
  assign bus_done = bus_req_q && ((data_size_ack != dec_pkg::ACK_NONE) || bus_error_in);
  assign exec_exc = (kind == dec_pkg::OP_ILL) || (kind == dec_pkg::OP_BACKGROUND_ENTRY_OP && !bgen_q);

  assign bus_req = bus_req_q;
  assign bus_wr = bus_wr_q;
  assign bus_fc = bus_fc_q;
  assign bus_addr = bus_addr_q;
  assign bus_wdata = bus_wdata_q;
  assign freeze = (state_q == dec_pkg::ST_FROZEN);

  // Software writes first; execution updates later in the block take priority
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      state_q <= dec_pkg::ST_IDLE;
      step_q <= 2'h0;
      half_q <= 1'b0;
      exc_q <= 1'b0;
      bgen_q <= 1'b0;
      cap_q <= 16'h0000;
      opword_q <= 16'h0000;
      ext_q <= 32'h0000_0000;
      bitsrc_q <= 32'h0000_0000;
      dst_q <= 32'h0000_0000;
      pc_q <= 32'h0000_0000;
      sr_q <= 16'h0000;
      result_q <= 32'h0000_0000;
      ssp_q <= 32'h0000_0000;
      vbr_q <= 32'h0000_0000;
      bus_req_q <= 1'b0;
      bus_wr_q <= 1'b0;
      bus_fc_q <= 3'h0;
      bus_addr_q <= 32'h0000_0000;
      bus_wdata_q <= 16'h0000;
    end
    else
    begin
      if (apb_wr)
      begin
        case (paddr)
          dec_pkg::ADDR_CTRL: bgen_q <= pwdata[dec_pkg::CTRL_BGEN];
          dec_pkg::ADDR_OPWORD: opword_q <= pwdata[15:0];
          dec_pkg::ADDR_EXT: ext_q <= pwdata;
          dec_pkg::ADDR_BITSRC: bitsrc_q <= pwdata;
          dec_pkg::ADDR_DST: dst_q <= pwdata;
          dec_pkg::ADDR_PC: pc_q <= pwdata;
          dec_pkg::ADDR_SR: sr_q <= pwdata[15:0];
          dec_pkg::ADDR_SSP: ssp_q <= pwdata;
          dec_pkg::ADDR_VBR: vbr_q <= pwdata;
          default: ;
        endcase
      end
      if (bus_done)
      begin
        bus_req_q <= 1'b0;
      end
      unique case (state_q)
        dec_pkg::ST_IDLE:
          if (start)
          begin
            state_q <= dec_pkg::ST_EXEC;
            exc_q <= 1'b0;
          end
        dec_pkg::ST_EXEC:
          if (exec_exc)
          begin
            state_q <= dec_pkg::ST_PUSH;
            step_q <= 2'h0;
            exc_q <= 1'b1;
          end
          else if (kind == dec_pkg::OP_BACKGROUND_ENTRY_OP)
          begin
            pc_q <= pc_q + dec_pkg::PC_STEP;
            state_q <= dec_pkg::ST_FROZEN;
          end
          else if (kind == dec_pkg::OP_BREAKPOINT_OP)
          begin
            half_q <= 1'b0;
            state_q <= dec_pkg::ST_ACK;
          end
          else if (kind == dec_pkg::OP_BRA)
          begin
            pc_q <= pc_q + dec_pkg::PC_STEP + disp;
            state_q <= dec_pkg::ST_IDLE;
          end
          else
          begin
            result_q <= bit_res;
            sr_q[dec_pkg::FLAG_Z] <= bit_zero;
            pc_q <= pc_q + (imm_form ? dec_pkg::IMM_LEN : dec_pkg::PC_STEP);
            state_q <= dec_pkg::ST_IDLE;
          end
        dec_pkg::ST_ACK:
          if (!bus_req_q)
          begin
            bus_req_q <= 1'b1;
            bus_wr_q <= 1'b0;
            bus_fc_q <= dec_pkg::FC_CPU;
            bus_addr_q <= half_q ? breakpoint_op_addr + dec_pkg::BYTE_STEP : breakpoint_op_addr;
          end
          else if (bus_done)
          begin
            if (bus_error_in)
            begin
              state_q <= dec_pkg::ST_PUSH;
              step_q <= 2'h0;
              exc_q <= 1'b1;
            end
            else if (data_size_ack == dec_pkg::ACK_BYTE && !half_q)
            begin
              cap_q[7:0] <= bus_rdata[15:8];
              half_q <= 1'b1;
            end
            else
            begin
              opword_q <= half_q ? {cap_q[7:0], bus_rdata[15:8]} : bus_rdata;
              state_q <= dec_pkg::ST_EXEC;
            end
          end
        dec_pkg::ST_FROZEN:
          if (resume)
          begin
            state_q <= dec_pkg::ST_IDLE;
          end
        dec_pkg::ST_PUSH:
          if (!bus_req_q)
          begin
            bus_req_q <= 1'b1;
            bus_wr_q <= 1'b1;
            bus_fc_q <= dec_pkg::FC_SUPV_DATA;
            bus_addr_q <= ssp_q - dec_pkg::PC_STEP;
            ssp_q <= ssp_q - dec_pkg::PC_STEP;
            bus_wdata_q <= frame_word(step_q, pc_q, sr_q);
          end
          else if (bus_done)
          begin
            step_q <= step_q + dec_pkg::STEP_ONE;
            if (step_q == dec_pkg::STEP_LAST)
            begin
              state_q <= dec_pkg::ST_VEC;
            end
          end
        dec_pkg::ST_VEC:
          if (!bus_req_q)
          begin
            bus_req_q <= 1'b1;
            bus_wr_q <= 1'b0;
            bus_fc_q <= dec_pkg::FC_SUPV_DATA;
            bus_addr_q <= vbr_q + dec_pkg::VEC_ILL_OFS + (step_q[0] ? dec_pkg::PC_STEP : 32'h0);
          end
          else if (bus_done)
          begin
            if (step_q[0])
            begin
              pc_q <= {cap_q, bus_rdata};
              state_q <= dec_pkg::ST_IDLE;
            end
            else
            begin
              cap_q <= bus_rdata;
              step_q <= dec_pkg::STEP_ONE;
            end
          end
      endcase
    end
  end

  // Checks on the externally visible behaviour
  wire logic in_exec;
  assign in_exec = (state_q == dec_pkg::ST_EXEC);

  property p_btc_flags;
    @(posedge sys_clk) disable iff (srst)
    in_exec && kind == dec_pkg::OP_BTC && !apb_wr |=> sr_q[dec_pkg::FLAG_Z] == $past(bit_zero)
      && sr_q[4:3] == $past(sr_q[4:3]) && sr_q[1:0] == $past(sr_q[1:0]);
  endproperty
  a_btc_flags: assert property (p_btc_flags) else $error("bit clear flag update wrong");

  property p_background_entry_op_freeze;
    @(posedge sys_clk) disable iff (srst)
    in_exec && kind == dec_pkg::OP_BACKGROUND_ENTRY_OP && bgen_q |=> freeze && sr_q == $past(sr_q);
  endproperty
  a_background_entry_op_freeze: assert property (p_background_entry_op_freeze) else $error("freeze not raised");

  property p_frozen_pc;
    @(posedge sys_clk) disable iff (srst)
    freeze && !apb_wr |=> pc_q == $past(pc_q);
  endproperty
  a_frozen_pc: assert property (p_frozen_pc) else $error("pc moved in background");

  property p_background_entry_op_off;
    @(posedge sys_clk) disable iff (srst)
    in_exec && kind == dec_pkg::OP_BACKGROUND_ENTRY_OP && !bgen_q |=> state_q == dec_pkg::ST_PUSH
      ##1 bus_req && bus_wr && bus_wdata == dec_pkg::FVO_ILL;
  endproperty
  a_background_entry_op_off: assert property (p_background_entry_op_off) else $error("disabled entry not trapped");

  property p_breakpoint_op_addr;
    @(posedge sys_clk) disable iff (srst)
    bus_req && state_q == dec_pkg::ST_ACK |-> bus_addr[4:2] == opword_q[2:0]
      && bus_fc == dec_pkg::FC_CPU && bus_addr[19:16] == dec_pkg::CPU_TYPE_BREAKPOINT_OP;
  endproperty
  a_breakpoint_op_addr: assert property (p_breakpoint_op_addr) else $error("breakpoint cycle address wrong");

  property p_breakpoint_op_word;
    @(posedge sys_clk) disable iff (srst)
    state_q == dec_pkg::ST_ACK && bus_done && !bus_error_in && !half_q
      && data_size_ack != dec_pkg::ACK_BYTE |=> in_exec && opword_q == $past(bus_rdata);
  endproperty
  a_breakpoint_op_word: assert property (p_breakpoint_op_word) else $error("returned word not executed");

  property p_byte_again;
    @(posedge sys_clk) disable iff (srst)
    state_q == dec_pkg::ST_ACK && bus_done && !bus_error_in && !half_q
      && data_size_ack == dec_pkg::ACK_BYTE |=> ##1 bus_req
      && bus_addr == $past(bus_addr, 2) + dec_pkg::BYTE_STEP;
  endproperty
  a_byte_again: assert property (p_byte_again) else $error("no second byte cycle");

  property p_breakpoint_op_err;
    @(posedge sys_clk) disable iff (srst)
    state_q == dec_pkg::ST_ACK && bus_done && bus_error_in |=> state_q == dec_pkg::ST_PUSH;
  endproperty
  a_breakpoint_op_err: assert property (p_breakpoint_op_err) else $error("bus error not trapped");

  property p_bra_pc;
    @(posedge sys_clk) disable iff (srst)
    in_exec && kind == dec_pkg::OP_BRA && !apb_wr |=>
      pc_q == $past(pc_q) + dec_pkg::PC_STEP + $past(disp);
  endproperty
  a_bra_pc: assert property (p_bra_pc) else $error("branch target wrong");
endmodule

/* File: test/bus_partner.sv */
/*
  Far-side bus model: answers each external bus cycle of the decoder.
  Assumes the bus is synchronous to sys_clk; in CPU space mode 0 word, 1 byte, 2 error.
*/
`timescale 1ns/1ns
module bus_partner (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic bus_req,
  input wire logic [2:0] bus_fc,
  input wire logic [31:0] bus_addr,
  input wire logic [1:0] mode,
  input wire logic [3:0] delay,
  input wire logic [15:0] word,
  output logic [15:0] bus_rdata,
  output logic [1:0] data_size_ack,
  output logic bus_error_in
);
  logic [3:0] cnt_q;
  logic hit_q;
  wire fire = bus_req && !hit_q && cnt_q == delay;
  wire cpu = bus_fc == 3'h7;
  wire err = cpu && mode == 2'h2;
  // Debug word in CPU space, address echo elsewhere; a byte port answers on 15:8
  wire [15:0] data = !cpu ? bus_addr[15:0] : mode != 2'h1 ? word :
    bus_addr[0] ? {word[7:0], 8'h00} : {word[15:8], 8'h00};
  // Wait count, so each cycle gets exactly one answer
  always_ff @(posedge sys_clk)
  begin
    if (srst || !bus_req)
    begin
      cnt_q <= 4'h0;
      hit_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 4'h1;
      hit_q <= hit_q | fire;
    end
  end
  // One-cycle answer; idle data inverts so a stale word never matches by luck
  always_ff @(posedge sys_clk)
  begin
    bus_error_in <= !srst && fire && err;
    data_size_ack <= (srst || !fire || err) ? 2'h0 :
      (cpu && mode == 2'h1) ? 2'h1 : 2'h2;
    bus_rdata <= srst ? 16'h0000 : fire ? data : ~bus_rdata;
  end
endmodule

/* File: test/tb_bit_branch_debug_op_decoder.sv */
/*
  Self-checking bench for the bit, branch and debug decoder.
  Assumes APB access and the far-side bus model bus_partner.
*/
`timescale 1ns/1ns
module tb_bit_branch_debug_op_decoder;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, bgen = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, bus_addr, q, cpu_addr = 32'h0;
  logic pready, pslverr, bus_req, bus_wr, freeze, bus_error_in, e;
  logic req_q = 1'b0;
  logic [2:0] bus_fc;
  logic [15:0] bus_wdata, bus_rdata, bk_word = 16'h0000, last_wr = 16'h0000;
  logic [1:0] data_size_ack, bk_mode = 2'h0;
  logic [3:0] bk_delay = 4'h0;
  int fail_count = 0, compares = 0, cpu_cycles = 0, wr_cycles = 0, n0;
  logic [15:0] bad_op [5] = '{16'h0D88, 16'h0DBC, 16'h0DBA, 16'hFFFF, 16'h0880};
  logic [31:0] bad_ext [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0103_0000};
  logic [15:0] br_op [5] = '{16'h6010, 16'h60FE, 16'h6000, 16'h6000, 16'h60FF};
  logic [31:0] br_ext [5] = '{32'h0, 32'h0, 32'hFFFC_0000, 32'h0, 32'h0001_0000};
  logic [31:0] br_pc [5] = '{32'h1012, 32'h1000, 32'hFFE, 32'h1002, 32'h11002};
  logic [1:0] bk_m [3] = '{2'h0, 2'h1, 2'h2};
  logic [15:0] bk_w [3] = '{16'h6008, 16'h6004, 16'h0000};
  logic [31:0] bk_a [3] = '{32'hC, 32'h15, 32'h1C};
  logic [31:0] bk_c [3] = '{32'h1, 32'h2, 32'h1};
  logic [31:0] bk_s [3] = '{32'h1, 32'h1, 32'h101};
  logic [31:0] bk_p [3] = '{32'h400A, 32'h4006, 32'h0210_0212};

  always #5 sys_clk = ~sys_clk;

  bit_branch_debug_op_decoder DUT (.sys_clk(sys_clk), .srst(srst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus_req(bus_req), .bus_wr(bus_wr),
    .bus_fc(bus_fc), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .data_size_ack(data_size_ack), .bus_error_in(bus_error_in), .freeze(freeze));

  bus_partner far_end (.sys_clk(sys_clk), .srst(srst), .bus_req(bus_req),
    .bus_fc(bus_fc), .bus_addr(bus_addr), .mode(bk_mode), .delay(bk_delay),
    .word(bk_word), .bus_rdata(bus_rdata), .data_size_ack(data_size_ack),
    .bus_error_in(bus_error_in));

  // Note each CPU-space cycle as it opens; byte ports show up as a second one
  always @(posedge sys_clk)
  begin
    req_q <= bus_req;
    if (bus_req === 1'b1 && req_q === 1'b0 && bus_fc === 3'h7)
    begin
      cpu_addr <= bus_addr;
      cpu_cycles <= cpu_cycles + 1;
    end
    // Stacking writes: keep the last word pushed and how many went out
    if (bus_req === 1'b1 && req_q === 1'b0 && bus_wr === 1'b1)
    begin
      last_wr <= bus_wdata;
      wr_cycles <= wr_cycles + 1;
    end
  end

  task automatic test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      fail_count++;
      test_done();
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  // Polls the state field; a limit keeps a stuck engine from hanging the run
  task automatic run(input logic [15:0] op, input logic [31:0] ext, input logic [31:0] pc,
    input logic [5:0] tgt);
    int n;
    if (op !== 16'h0000)
    begin
      apb(1'b1, dec_pkg::ADDR_OPWORD, {16'h0000, op});
      apb(1'b1, dec_pkg::ADDR_EXT, ext);
      apb(1'b1, dec_pkg::ADDR_PC, pc);
      apb(1'b1, dec_pkg::ADDR_CTRL, {30'h0, 1'b1, bgen});
    end
    q = 32'h0;
    for (n = 0; n < 60 && q[5:0] !== tgt; n++)
      apb(1'b0, dec_pkg::ADDR_STAT, 32'h0);
    if (q[5:0] !== tgt)
    begin
      fail_count++;
      test_done();
    end
  endtask

  // Z goes in inverted so a result that leaves it alone is caught
  task automatic bit_case(input logic [15:0] op, input logic [31:0] ext, src, dst, res,
    input logic [15:0] sr, input logic [31:0] step);
    apb(1'b1, dec_pkg::ADDR_BITSRC, src);
    apb(1'b1, dec_pkg::ADDR_DST, dst);
    apb(1'b1, dec_pkg::ADDR_SR, {16'h0000, sr ^ 16'h0004});
    run(op, ext, 32'h100, 6'h01);
    rdchk(dec_pkg::ADDR_RESULT, res);
    rdchk(dec_pkg::ADDR_SR, {16'h0000, sr});
    rdchk(dec_pkg::ADDR_PC, 32'h100 + step);
  endtask

  initial
  begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    rdchk(dec_pkg::ADDR_STAT, 32'h1);
    apb(1'b0, 8'hFC, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("test reset done");
    bit_case(16'h0D80, 32'h0, 32'h21, 32'h3, 32'h1, 16'h001B, 32'h2);
    bit_case(16'h0D90, 32'h0, 32'h9, 32'hF02, 32'h0, 16'h001B, 32'h2);
    bit_case(16'h0DB9, 32'h0, 32'h7, 32'h80, 32'h0, 16'h0000, 32'h2);
    bit_case(16'h0880, 32'h0003_0000, 32'h0, 32'h0, 32'h0, 16'h0015, 32'h4);
    bit_case(16'h01C0, 32'h0, 32'h0, 32'h0, 32'h1, 16'h000E, 32'h2);
    bit_case(16'h08C0, 32'h001F_0000, 32'h0, 32'h7FFF_FFFF, 32'hFFFF_FFFF, 16'h0004, 32'h4);
    foreach (bad_op[i])
    begin
      run(bad_op[i], bad_ext[i], 32'h100, 6'h01);
      rdchk(dec_pkg::ADDR_STAT, 32'h101);
    end
    $display("test bit ops done");
    apb(1'b1, dec_pkg::ADDR_SR, 32'h1F);
    foreach (br_op[i])
    begin
      run(br_op[i], br_ext[i], 32'h1000, 6'h01);
      rdchk(dec_pkg::ADDR_PC, br_pc[i]);
    end
    rdchk(dec_pkg::ADDR_SR, 32'h1F);
    $display("test branch done");
    bgen = 1'b1;
    apb(1'b1, dec_pkg::ADDR_SR, 32'h15);
    run(16'h4AFA, 32'h0, 32'h2000, 6'h08);
    chk({31'h0, freeze}, 32'h1);
    rdchk(dec_pkg::ADDR_SR, 32'h15);
    apb(1'b1, dec_pkg::ADDR_CTRL, 32'h5);
    run(16'h0000, 32'h0, 32'h0, 6'h01);
    chk({31'h0, freeze}, 32'h0);
    rdchk(dec_pkg::ADDR_PC, 32'h2002);
    bgen = 1'b0;
    apb(1'b1, dec_pkg::ADDR_SSP, 32'h400);
    apb(1'b1, dec_pkg::ADDR_VBR, 32'h200);
    n0 = wr_cycles;
    run(16'h4AFA, 32'h0, 32'h3000, 6'h01);
    chk({16'h0000, last_wr}, 32'h15);
    chk(32'(wr_cycles - n0), 32'h4);
    rdchk(dec_pkg::ADDR_STAT, 32'h101);
    rdchk(dec_pkg::ADDR_SSP, 32'h3F8);
    rdchk(dec_pkg::ADDR_PC, 32'h0210_0212);
    $display("test background done");
    foreach (bk_m[i])
    begin
      bk_mode <= bk_m[i];
      bk_delay <= 4'(2 * i);
      bk_word <= bk_w[i];
      n0 = cpu_cycles;
      run(16'h4848 | 16'(3 + 2 * i), 32'h0, 32'h4000, 6'h01);
      chk(cpu_addr, bk_a[i]);
      chk(32'(cpu_cycles - n0), bk_c[i]);
      rdchk(dec_pkg::ADDR_STAT, bk_s[i]);
      rdchk(dec_pkg::ADDR_PC, bk_p[i]);
    end
    $display("test breakpoint done");
    test_done();
  end
endmodule
